// File: pkg/alss_cfg.svh
// Purpose: Constants of the converter start-up sequencer pair
// Assumes: 125 MHz mclk on both ends
// Notes: Field codes select one control field per write
`ifndef ALSS_CFG_SVH
`define ALSS_CFG_SVH

// ==========================================================
// Field select codes carried by each write
`define ALSS_F_RESTART 4'h0
`define ALSS_F_LINK_EN 4'h1
`define ALSS_F_CAL_EN 4'h2
`define ALSS_F_MODE 4'h3
`define ALSS_F_KM1 4'h4
`define ALSS_F_SYNC_SEL 4'h5
`define ALSS_F_CAL_OPT 4'h6
`define ALSS_F_OVERRANGE_ENABLE 4'h7
`define ALSS_F_CAL_TRIG 4'h8

// ==========================================================
// Bit positions inside the calibration option word
`define ALSS_OPT_BG_BIT 0
`define ALSS_OPT_OFS_BIT 1

// ==========================================================
// Reset values of the device fields
`define ALSS_RST_LINK_EN 1'b1
`define ALSS_RST_CAL_EN 1'b1
`define ALSS_RST_MODE 5'h00
`define ALSS_RST_KM1 5'h1F
`define ALSS_RST_SYNC_SEL 1'b0
`define ALSS_RST_OVERRANGE_ENABLE 1'b0

// ==========================================================
// Timing
`define ALSS_CLK_MHZ 125
`define ALSS_RESTART_WAIT_NS 1000
`define ALSS_RESTART_WAIT_CYC \
  ((`ALSS_RESTART_WAIT_NS * `ALSS_CLK_MHZ + 999) / 1000)
`define ALSS_HWRST_CYC 16
`define ALSS_ILAS_MULTIFRAMES 4
`define ALSS_CAL_RUN_CYC 64

`endif

// File: pkg/alss_pkg.sv
// Purpose: Types shared by both ends of the start-up sequencer
// Assumes: Constants live in alss_cfg.svh
// Notes: One-hot state codes
package alss_pkg;

  // ==========================================================
  // Host sequencer states
  typedef enum logic [6:0] {
    H_IDLE = 7'h01,
    H_HWRST = 7'h02,
    H_CLKW = 7'h04,
    H_WRITE = 7'h08,
    H_ACK = 7'h10,
    H_HOLD = 7'h20,
    H_DONE = 7'h40
  } alss_host_st_t;

  // ==========================================================
  // Device serial link states
  typedef enum logic [3:0] {
    L_HALT = 4'h1,
    L_WSYNC = 4'h2,
    L_ILAS = 4'h4,
    L_DATA = 4'h8
  } alss_link_st_t;

endpackage

// File: pkg/alss_if.sv
// Purpose: Control link between host and converter end
// Assumes: Both ends share mclk
// Notes: wr_req holds until a one-cycle wr_ack
`timescale 1ns/100ps
`default_nettype none
interface alss_if;
  logic dev_rst;       // Hardware reset of the converter
  logic wr_req;        // Write request, held until ack
  logic [3:0] wr_field; // Field select code
  logic [15:0] wr_data; // Field value
  logic wr_ack;        // One-cycle write acknowledge

  modport host (output dev_rst, output wr_req, output wr_field,
    output wr_data, input wr_ack);
  modport dev (input dev_rst, input wr_req, input wr_field,
    input wr_data, output wr_ack);
endinterface
`default_nettype wire

// File: hdl/alss_wait_timer.sv
// Purpose: Down-counter giving a hold-off period
// Assumes: start is a one-cycle pulse
// Notes: done is a level, high while idle or expired
`timescale 1ns/100ps
`default_nettype none
module alss_wait_timer #(
  parameter int W = 8
) (
  input wire logic mclk,             // Clock
  input wire logic sys_rst,          // Synchronous reset
  input wire logic start,            // Load pulse
  input wire logic [W-1:0] load_val, // Cycles to wait
  output logic done                  // Period has expired
);
  logic [W-1:0] cnt;

  // Count down from the loaded value
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt <= '0;
      done <= 1'b1;
    end else if (start) begin
      cnt <= load_val;
      done <= 1'b0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1'b1;
    end else begin
      cnt <= '0;
      done <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: hdl/alss_host.sv
// Purpose: Host end: runs the converter start-up sequence
// Assumes: clk_stable reports the sample clock has settled
// Notes: One write at a time, steps never reordered
`timescale 1ns/100ps
`default_nettype none
`include "alss_cfg.svh"

// How it works
// - Reset device, await stable clock, then configure
// - Pulse restart, then wait one microsecond
// - Clear link enable before link settings
// - Clear calibration enable before its settings
// - Write link mode with both machines halted
// - Write multiframe length minus one after mode
// - Sync source picks single-ended or timestamp pair
// - Set foreground/background and offset calibration
// - Set calibration enable after options
// - Optionally enable overrange before link restart
// - Set link enable after all settings
// - Link advances by receiver sync request
// - Trigger bit zero then one starts calibration
module alss_host #(
  parameter int MW = 5,                    // Link mode width
  parameter int KW = 5,                    // Multiframe field width
  parameter int HWRST_CYC = `ALSS_HWRST_CYC
) (
  input wire logic mclk,              // Clock
  input wire logic sys_rst,           // Synchronous reset
  input wire logic start,             // Begin the sequence
  input wire logic clk_stable,        // Sample clock is stable
  input wire logic [MW-1:0] cfg_mode, // Wanted link mode
  input wire logic [KW:0] cfg_frames, // Frames per multiframe
  input wire logic cfg_sync_ts,       // Use timestamp pair for sync
  input wire logic cfg_cal_bg,        // Background calibration
  input wire logic cfg_cal_ofs,       // Offset calibration
  input wire logic cfg_overrange_enable,        // Overrange detection
  output logic busy,                  // Sequence in progress
  output logic done,                  // Sequence complete
  alss_if.host lnk                    // Link to converter end
);
  localparam int WAIT_CYC = `ALSS_RESTART_WAIT_CYC;
  localparam int LAST_STEP = 11;

  alss_pkg::alss_host_st_t st;
  logic [3:0] step;
  logic tmr_start;
  logic [7:0] tmr_load;
  logic tmr_done;
  logic [3:0] next_field;
  logic [15:0] next_data;
  logic [MW-1:0] mode_q;
  logic [KW-1:0] km1_q;
  logic [3:0] opt_q;

  // ==========================================================
  // Hold-off timer for hardware reset and restart wait
  alss_wait_timer #(
    .W(8)
  ) u_tmr (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(tmr_start),
    .load_val(tmr_load),
    .done(tmr_done)
  );

  // ==========================================================
  // Field and value for each step, in fixed order
  always_comb begin
    next_field = `ALSS_F_RESTART;
    next_data = 16'h0000;
    case (step)
      4'd0: begin
        next_field = `ALSS_F_RESTART;
        next_data = 16'h0001;
      end
      4'd1: begin
        next_field = `ALSS_F_LINK_EN;
        next_data = 16'h0000;
      end
      4'd2: begin
        next_field = `ALSS_F_CAL_EN;
        next_data = 16'h0000;
      end
      4'd3: begin
        next_field = `ALSS_F_MODE;
        next_data = 16'(mode_q);
      end
      4'd4: begin
        next_field = `ALSS_F_KM1;
        next_data = 16'(km1_q);
      end
      4'd5: begin
        next_field = `ALSS_F_SYNC_SEL;
        next_data = {12'h000, opt_q[2], 3'b000};
      end
      4'd6: begin
        next_field = `ALSS_F_CAL_OPT;
        next_data = {14'h0000, opt_q[1:0]};
      end
      4'd7: begin
        next_field = `ALSS_F_CAL_EN;
        next_data = 16'h0001;
      end
      4'd8: begin
        next_field = `ALSS_F_OVERRANGE_ENABLE;
        next_data = {15'h0000, opt_q[3]};
      end
      4'd9: begin
        next_field = `ALSS_F_LINK_EN;
        next_data = 16'h0001;
      end
      4'd10: begin
        next_field = `ALSS_F_CAL_TRIG;
        next_data = 16'h0000;
      end
      4'd11: begin
        next_field = `ALSS_F_CAL_TRIG;
        next_data = 16'h0001;
      end
      default: begin
        next_field = `ALSS_F_RESTART;
        next_data = 16'h0000;
      end
    endcase
  end

  // ==========================================================
  // Capture the wanted settings when the sequence starts
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_q <= '0;
      km1_q <= '0;
      opt_q <= 4'h0;
    end else if (start && (st == alss_pkg::H_IDLE ||
        st == alss_pkg::H_DONE)) begin
      // A restart from DONE must take the new settings as well
      mode_q <= cfg_mode;
      km1_q <= KW'(cfg_frames - 1'b1);
      opt_q <= {cfg_overrange_enable, cfg_sync_ts, cfg_cal_ofs, cfg_cal_bg};
    end
  end

  // ==========================================================
  // Sequence state machine
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= alss_pkg::H_IDLE;
      step <= 4'h0;
      tmr_start <= 1'b0;
      tmr_load <= 8'h00;
    end else begin
      tmr_start <= 1'b0;
      case (st)
        alss_pkg::H_IDLE: begin
          if (start) begin
            st <= alss_pkg::H_HWRST;
            tmr_start <= 1'b1;
            tmr_load <= 8'(HWRST_CYC);
          end
        end
        alss_pkg::H_HWRST: begin
          if (tmr_done && !tmr_start) begin
            st <= alss_pkg::H_CLKW;
          end
        end
        alss_pkg::H_CLKW: begin
          if (clk_stable) begin
            st <= alss_pkg::H_WRITE;
            step <= 4'h0;
          end
        end
        alss_pkg::H_WRITE: begin
          st <= alss_pkg::H_ACK;
        end
        alss_pkg::H_ACK: begin
          if (lnk.wr_ack) begin
            if (step == 4'h0) begin
              st <= alss_pkg::H_HOLD;
              tmr_start <= 1'b1;
              tmr_load <= 8'(WAIT_CYC);
            end else if (step == 4'(LAST_STEP)) begin
              st <= alss_pkg::H_DONE;
            end else begin
              st <= alss_pkg::H_WRITE;
            end
            step <= step + 1'b1;
          end
        end
        alss_pkg::H_HOLD: begin
          if (tmr_done && !tmr_start) begin
            st <= alss_pkg::H_WRITE;
          end
        end
        alss_pkg::H_DONE: begin
          if (start) begin
            st <= alss_pkg::H_HWRST;
            tmr_start <= 1'b1;
            tmr_load <= 8'(HWRST_CYC);
          end
        end
        default: st <= alss_pkg::H_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Link drive: reset line and held write request
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lnk.dev_rst <= 1'b0;
      lnk.wr_req <= 1'b0;
      lnk.wr_field <= 4'h0;
      lnk.wr_data <= 16'h0000;
    end else begin
      lnk.dev_rst <= (st == alss_pkg::H_HWRST) && !tmr_done;
      if (st == alss_pkg::H_WRITE) begin
        lnk.wr_req <= 1'b1;
        lnk.wr_field <= next_field;
        lnk.wr_data <= next_data;
      end else if (lnk.wr_ack) begin
        lnk.wr_req <= 1'b0;
      end
    end
  end

  // Status outputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      busy <= !(st == alss_pkg::H_IDLE || st == alss_pkg::H_DONE);
      done <= (st == alss_pkg::H_DONE);
    end
  end
endmodule
`default_nettype wire

// File: hdl/alss_dev.sv
// Purpose: Converter end: control fields, link and calibration
// Assumes: Sync inputs are active low and synchronous to mclk
// Notes: Settings writes other than overrange are ignored while their machine runs
`timescale 1ns/100ps
`default_nettype none
`include "alss_cfg.svh"
module alss_dev #(
  parameter int MW = 5,                    // Link mode width
  parameter int KW = 5,                    // Multiframe field width
  parameter int CAL_CYC = `ALSS_CAL_RUN_CYC
) (
  input wire logic mclk,          // Clock
  input wire logic sys_rst,       // Synchronous reset
  input wire logic sync_se_n,     // Single-ended sync request
  input wire logic sync_ts_n,     // Timestamp pair sync request
  output logic link_enable,       // Link machine enabled
  output logic cal_run_enable,    // Calibration machine enabled
  output logic [MW-1:0] link_mode_select, // Output format
  output logic [KW-1:0] multiframe_length_minus_one, // K-1
  output logic sync_from_ts,      // Sync taken from timestamp pair
  output logic cal_background,    // Background calibration
  output logic cal_offset,        // Offset calibration
  output logic overrange_enable,  // Overrange detection
  output logic cal_busy,          // Calibration run active
  output logic [3:0] link_state,  // Link state, one-hot
  output logic data_valid,        // Sample data flowing
  alss_if.dev lnk                 // Link from host
);
  localparam int ILAS_W = KW + 3;

  alss_pkg::alss_link_st_t lst;
  logic rst_all;
  logic wr_take;
  logic trig_prev;
  logic sync_n;
  logic [ILAS_W-1:0] ilas_cnt;
  logic [15:0] cal_cnt;

  assign rst_all = sys_rst || lnk.dev_rst;
  assign wr_take = lnk.wr_req && !lnk.wr_ack;

  // Acknowledge each write one cycle after it is seen
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lnk.wr_ack <= 1'b0;
    end else begin
      lnk.wr_ack <= wr_take;
    end
  end

  // ==========================================================
  // Control fields; restart returns them to defaults
  always_ff @(posedge mclk) begin
    if (rst_all || (wr_take && lnk.wr_field == `ALSS_F_RESTART &&
        lnk.wr_data[0])) begin
      link_enable <= `ALSS_RST_LINK_EN;
      cal_run_enable <= `ALSS_RST_CAL_EN;
      link_mode_select <= MW'(`ALSS_RST_MODE);
      multiframe_length_minus_one <= KW'(`ALSS_RST_KM1);
      sync_from_ts <= `ALSS_RST_SYNC_SEL;
      cal_background <= 1'b0;
      cal_offset <= 1'b0;
      overrange_enable <= `ALSS_RST_OVERRANGE_ENABLE;
      trig_prev <= 1'b0;
    end else if (wr_take) begin
      case (lnk.wr_field)
        `ALSS_F_LINK_EN: link_enable <= lnk.wr_data[0];
        `ALSS_F_CAL_EN: cal_run_enable <= lnk.wr_data[0];
        `ALSS_F_MODE: begin
          if (!link_enable && !cal_run_enable) begin
            link_mode_select <= lnk.wr_data[MW-1:0];
          end
        end
        `ALSS_F_KM1: begin
          if (!link_enable) begin
            multiframe_length_minus_one <= lnk.wr_data[KW-1:0];
          end
        end
        `ALSS_F_SYNC_SEL: begin
          if (!link_enable) begin
            sync_from_ts <= lnk.wr_data[3];
          end
        end
        `ALSS_F_CAL_OPT: begin
          if (!cal_run_enable) begin
            cal_background <= lnk.wr_data[`ALSS_OPT_BG_BIT];
            cal_offset <= lnk.wr_data[`ALSS_OPT_OFS_BIT];
          end
        end
        `ALSS_F_OVERRANGE_ENABLE: overrange_enable <= lnk.wr_data[0];
        `ALSS_F_CAL_TRIG: trig_prev <= lnk.wr_data[0];
        default: trig_prev <= trig_prev;
      endcase
    end
  end

  // ==========================================================
  // Calibration run, started on a rising trigger
  always_ff @(posedge mclk) begin
    if (rst_all || !cal_run_enable) begin
      cal_cnt <= 16'h0000;
      cal_busy <= 1'b0;
    end else if (wr_take && lnk.wr_field == `ALSS_F_CAL_TRIG &&
        lnk.wr_data[0] && !trig_prev) begin
      cal_cnt <= 16'(CAL_CYC);
      cal_busy <= 1'b1;
    end else if (cal_cnt > 16'h0001) begin
      cal_cnt <= cal_cnt - 16'h0001;
    end else begin
      cal_cnt <= 16'h0000;
      cal_busy <= 1'b0;
    end
  end

  // Sync request from the selected source
  assign sync_n = sync_from_ts ? sync_ts_n : sync_se_n;

  // ==========================================================
  // Link state machine driven by the receiver's sync request
  always_ff @(posedge mclk) begin
    if (rst_all) begin
      lst <= alss_pkg::L_HALT;
      ilas_cnt <= '0;
    end else if (!link_enable) begin
      lst <= alss_pkg::L_HALT;
      ilas_cnt <= '0;
    end else begin
      case (lst)
        alss_pkg::L_HALT: lst <= alss_pkg::L_WSYNC;
        alss_pkg::L_WSYNC: begin
          if (sync_n) begin
            lst <= alss_pkg::L_ILAS;
            ilas_cnt <= ILAS_W'(`ALSS_ILAS_MULTIFRAMES *
              (int'(multiframe_length_minus_one) + 1) - 1);
          end
        end
        alss_pkg::L_ILAS: begin
          if (!sync_n) begin
            lst <= alss_pkg::L_WSYNC;
          end else if (ilas_cnt == '0) begin
            lst <= alss_pkg::L_DATA;
          end else begin
            ilas_cnt <= ilas_cnt - 1'b1;
          end
        end
        alss_pkg::L_DATA: begin
          if (!sync_n) begin
            lst <= alss_pkg::L_WSYNC;
          end
        end
        default: lst <= alss_pkg::L_HALT;
      endcase
    end
  end

  // Registered link status
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      link_state <= 4'h1;
      data_valid <= 1'b0;
    end else begin
      link_state <= lst;
      data_valid <= (lst == alss_pkg::L_DATA);
    end
  end
endmodule
`default_nettype wire

// File: sim/alss_props.sv
// Purpose: Assertions on the host-to-converter control link
// Assumes: One clock domain, sys_rst synchronous active high
// Notes: Step count restarts with each converter hardware reset
`timescale 1ns/100ps
`default_nettype none
`include "alss_cfg.svh"
module alss_props (
  input wire logic mclk,           // Clock
  input wire logic sys_rst,        // Synchronous reset
  input wire logic dev_rst,        // Converter hardware reset
  input wire logic wr_req,         // Write request
  input wire logic [3:0] wr_field, // Field select code
  input wire logic [15:0] wr_data, // Field value
  input wire logic wr_ack          // Write acknowledge
);
  localparam int HOLD_CYC = `ALSS_RESTART_WAIT_CYC;
  logic [3:0] step;
  logic [7:0] hold_cnt;

  // ==========================================================
  // Helper logic
  // Writes accepted since the last converter reset
  always_ff @(posedge mclk) begin
    if (sys_rst || dev_rst)
      step <= 4'h0;
    else if (wr_req && wr_ack && step != 4'hF)
      step <= step + 4'h1;
  end

  // Cycles since the restart write was acknowledged, saturating
  always_ff @(posedge mclk) begin
    if (sys_rst)
      hold_cnt <= 8'h00;
    else if (wr_req && wr_ack && wr_field == `ALSS_F_RESTART)
      hold_cnt <= 8'h01;
    else if (hold_cnt != 8'h00 && hold_cnt != 8'hFF)
      hold_cnt <= hold_cnt + 8'h01;
  end

  // Field code due at each step of the start-up sequence
  function automatic logic [3:0] exp_field(input logic [3:0] s);
    case (s)
      4'h0: exp_field = `ALSS_F_RESTART;
      4'h1, 4'h9: exp_field = `ALSS_F_LINK_EN;
      4'h2, 4'h7: exp_field = `ALSS_F_CAL_EN;
      4'h3: exp_field = `ALSS_F_MODE;
      4'h4: exp_field = `ALSS_F_KM1;
      4'h5: exp_field = `ALSS_F_SYNC_SEL;
      4'h6: exp_field = `ALSS_F_CAL_OPT;
      4'h8: exp_field = `ALSS_F_OVERRANGE_ENABLE;
      default: exp_field = `ALSS_F_CAL_TRIG;
    endcase
  endfunction

  // ==========================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // A write is taken, acked for one cycle, then released
  sequence s_take;
    wr_req && !wr_ack ##1
      wr_req && wr_ack && $stable(wr_field) && $stable(wr_data);
  endsequence
  sequence s_release;
    !wr_req && !wr_ack;
  endsequence

  chk_write_handshake: assert property (
    $rose(wr_req) |-> s_take ##1 s_release)
    else $error("write handshake broken");
  chk_ack_cause: assert property (
    wr_ack |-> $past(wr_req) && !$past(wr_ack))
    else $error("ack without a pending request");
  chk_quiet_in_reset: assert property (
    dev_rst |-> !wr_req)
    else $error("write during converter reset");
  chk_restart_hold: assert property (
    $rose(wr_req) && hold_cnt != 8'h00 |-> hold_cnt >= HOLD_CYC)
    else $error("write too soon after restart");
  chk_restart_bit: assert property (
    wr_req && step == 4'h0 |-> wr_data[0])
    else $error("restart write without restart bit");
  chk_step_order: assert property (
    wr_req && step < 4'hC |-> wr_field == exp_field(step))
    else $error("sequence step out of order");
  chk_link_halt: assert property (
    wr_req && step == 4'h1 |-> !wr_data[0])
    else $error("link not halted first");
  chk_cal_halt: assert property (
    wr_req && step == 4'h2 |-> !wr_data[0])
    else $error("calibration not halted");
  chk_cal_rearm: assert property (
    wr_req && step == 4'h7 |-> wr_data[0])
    else $error("calibration not re-enabled");
  chk_link_restart: assert property (
    wr_req && step == 4'h9 |-> wr_data[0])
    else $error("link not re-enabled");
  chk_trig_edge: assert property (
    wr_req && wr_ack && step == 4'hA |-> !wr_data[0] ##[1:6]
      (wr_req && wr_data[0] && wr_field == `ALSS_F_CAL_TRIG))
    else $error("trigger not written low then high");
endmodule
`default_nettype wire

// File: sim/tb.sv
// Purpose: Self-checking bench for the start-up sequencer pair
// Assumes: Both ends share mclk and one alss_if
// Notes: Each accepted start leaves one note in the queue
`timescale 1ns/100ps
`default_nettype none
`include "alss_cfg.svh"
module tb;
  typedef struct packed {
    logic [4:0] mode;
    logic [4:0] km1;
    logic ts;
    logic bg;
    logic ofs;
    logic ovr;
  } alss_exp_t;
  logic mclk, sys_rst, start, clk_stable, done_q;
  logic req_early = 1'b0;
  logic [4:0] cfg_mode;
  logic [5:0] cfg_frames;
  logic cfg_sync_ts, cfg_cal_bg, cfg_cal_ofs, cfg_overrange_enable;
  logic sync_se_n, sync_ts_n, busy, done, data_valid, cal_busy;
  logic link_enable, cal_run_enable, sync_from_ts, cal_background;
  logic cal_offset, overrange_enable;
  logic [4:0] link_mode_select, multiframe_length_minus_one;
  logic [3:0] link_state;
  int err_total = 0, n_tests = 0, cyc = 0, seed, n, k;
  alss_exp_t exp_q[$];
  alss_exp_t e, x;
  wire logic [15:0] fields;

  // ==========================================================
  // Design pair and checker
  alss_if lnk();
  alss_host i_alss_host (
    .mclk(mclk), .sys_rst(sys_rst), .start(start),
    .clk_stable(clk_stable), .cfg_mode(cfg_mode), .cfg_frames(cfg_frames),
    .cfg_sync_ts(cfg_sync_ts), .cfg_cal_bg(cfg_cal_bg),
    .cfg_cal_ofs(cfg_cal_ofs), .cfg_overrange_enable(cfg_overrange_enable),
    .busy(busy), .done(done), .lnk(lnk));
  alss_dev i_alss_dev (
    .mclk(mclk), .sys_rst(sys_rst), .sync_se_n(sync_se_n),
    .sync_ts_n(sync_ts_n), .link_enable(link_enable),
    .cal_run_enable(cal_run_enable), .link_mode_select(link_mode_select),
    .multiframe_length_minus_one(multiframe_length_minus_one),
    .sync_from_ts(sync_from_ts), .cal_background(cal_background),
    .cal_offset(cal_offset), .overrange_enable(overrange_enable),
    .cal_busy(cal_busy), .link_state(link_state),
    .data_valid(data_valid), .lnk(lnk));
  alss_props i_alss_props (
    .mclk(mclk), .sys_rst(sys_rst), .dev_rst(lnk.dev_rst),
    .wr_req(lnk.wr_req), .wr_field(lnk.wr_field), .wr_data(lnk.wr_data),
    .wr_ack(lnk.wr_ack));
  // Device fields packed for one comparison
  assign fields = {link_mode_select, multiframe_length_minus_one,
    sync_from_ts, cal_background, cal_offset, overrange_enable,
    link_enable, cal_run_enable};

  // ==========================================================
  // Checking and reporting
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: saw %h, want %h", $time, seen, want);
    end
  endtask
  task tally_and_finish;
    $display("Checks %0d, errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Clock at 125 MHz
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish;
    end
  end

  // Watch done and compare against the oldest note
  always @(posedge mclk) begin
    done_q <= done;
    if (start === 1'b1)
      req_early <= 1'b0;
    else if (lnk.wr_req === 1'b1 && clk_stable === 1'b0)
      req_early <= 1'b1;
    if (done === 1'b1 && done_q !== 1'b1) begin
      if (exp_q.size() == 0)
        check(16'h0000, 16'h0001);
      else begin
        x = exp_q.pop_front();
        check(fields, {x, 2'b11});
        check({15'h0000, cal_busy}, 16'h0001);
      end
    end
  end

  // ==========================================================
  // Stimulus
  initial begin
    seed = 50400;
    sys_rst = 1'b1;
    start = 1'b0;
    clk_stable = 1'b0;
    cfg_mode = 5'h00;
    cfg_frames = 6'h01;
    {cfg_sync_ts, cfg_cal_bg, cfg_cal_ofs, cfg_overrange_enable} = 4'h0;
    sync_se_n = 1'b0;
    sync_ts_n = 1'b0;
    repeat (8) @(posedge mclk);
    check(fields & 16'hFFE7, {`ALSS_RST_MODE, `ALSS_RST_KM1,
      `ALSS_RST_SYNC_SEL, 2'b00, `ALSS_RST_OVERRANGE_ENABLE, `ALSS_RST_LINK_EN,
      `ALSS_RST_CAL_EN});
    check({12'h000, link_state}, 16'h0001);
    check({13'h0000, busy, done, cal_busy}, 16'h0000);
    sys_rst <= 1'b0;
    for (int r = 0; r < 5; r++) begin
      n = $random(seed);
      k = (r == 0) ? 1 : (r == 1) ? 32 : int'(n[13:9]) + 1;
      e.mode = n[4:0];
      e.km1 = 5'(k - 1);
      {e.ts, e.bg, e.ofs, e.ovr} = n[8:5];
      // First two runs use each sync source once
      if (r < 2)
        e.ts = r[0];
      exp_q.push_back(e);
      @(posedge mclk);
      start <= 1'b1;
      clk_stable <= 1'b0;
      cfg_mode <= e.mode;
      cfg_frames <= 6'(k);
      {cfg_sync_ts, cfg_cal_bg, cfg_cal_ofs, cfg_overrange_enable} <=
        {e.ts, e.bg, e.ofs, e.ovr};
      @(posedge mclk);
      start <= 1'b0;
      repeat (9) @(posedge mclk);
      // A second start while busy must leave the first settings in force
      start <= 1'b1;
      cfg_mode <= ~e.mode;
      cfg_frames <= 6'(33 - k);
      @(posedge mclk);
      start <= 1'b0;
      repeat (30) @(posedge mclk);
      check({15'h0000, req_early}, 16'h0000);
      check({15'h0000, busy}, 16'h0001);
      clk_stable <= 1'b1;
      while (done !== 1'b1)
        @(posedge mclk);
      @(posedge mclk);
      check({12'h000, link_state}, 16'h0002);
      // Release only the selected sync line; the other stays requesting
      if (e.ts)
        sync_ts_n <= 1'b1;
      else
        sync_se_n <= 1'b1;
      n = 0;
      while (data_valid !== 1'b1 && n < 200) begin
        @(posedge mclk);
        n++;
      end
      check({15'h0000, (n >= 4 * k && n <= 4 * k + 4)},
        16'h0001);
      repeat (2) @(posedge mclk);
      check({12'h000, link_state}, 16'h0008);
      sync_se_n <= 1'b0;
      sync_ts_n <= 1'b0;
      repeat (3) @(posedge mclk);
      check({11'h000, link_state, data_valid}, 16'h0004);
    end
    repeat (4) @(posedge mclk);
    check(16'(exp_q.size()), 16'h0000);
    tally_and_finish;
  end
endmodule
`default_nettype wire
